// ---- bench/dbrpc_pin_ctrl_chk.sv ----
// concurrent checks on the pin control top ports
// assumes binding to dbrpc_pin_ctrl with shortened debounce parameters
`timescale 1ns/1ps
`default_nettype none

module dbrpc_pin_ctrl_chk
	import dbrpc_pkg::*;
#(
	parameter logic [31:0] DBNC_STEP = 32'h14,
	parameter logic [31:0] PWR_HOLD  = 32'hC8
) (
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	input  wire logic                  debug_gate_pin,
	input  wire logic                  global_reset_pin,
	input  wire logic                  gpio_pin_5_pd,
	input  wire logic                  gpio_pin_10_oe,
	input  wire logic                  gpio_pin_16_o,
	input  wire logic                  gpio_pin_16_oe,
	input  wire logic                  gpio_pin_17_oe,
	input  wire logic [6:0]            sw_pin_oe,
	input  wire logic                  mon_ctrl_wr,
	input  wire logic [31:0]           mon_ctrl_wdata,
	input  wire logic                  port_sel_wr,
	input  wire logic [31:0]           port_sel_wdata,
	input  wire logic [2:0]            dbnc_sel,
	input  wire logic                  trace_data,
	input  wire dbrpc_pkg::dbrpc_mode_t debug_mode,
	input  wire logic                  trace_enable,
	input  wire logic                  jtag_selected,
	input  wire logic                  boot_valid,
	input  wire logic                  flash_boot,
	input  wire logic                  serial_loader_mode,
	input  wire logic                  func_reset,
	input  wire logic                  power_reset
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	logic [31:0] low_cnt_q;
	logic [31:0] lim;
	// raw low time of the reset pin; sync delay makes it lead the design's count
	always_ff @(posedge core_clk) begin
		if (reset || global_reset_pin) low_cnt_q <= 32'h0;
		else low_cnt_q <= low_cnt_q + 32'h1;
	end
	assign lim = DBNC_STEP * (32'(dbnc_sel) + 32'h1);

	sequence s_gate_low;
		!debug_gate_pin [*5];
	endsequence
	sequence s_loader_on;
		serial_loader_mode [*2];
	endsequence

	a_strap_pull_down: assert property (gpio_pin_5_pd) else $error("pull-down off");
	a_gate_low_off: assert property (s_gate_low |-> debug_mode == DBRPC_OFF)
		else $error("gate low but debug on");
	a_off_pins_free: assert property (debug_mode == DBRPC_OFF |=>
		gpio_pin_17_oe == $past(sw_pin_oe[5])) else $error("pin17 not software owned");
	a_jtag_tdo_drive: assert property (debug_mode == DBRPC_JTAG |=> gpio_pin_16_oe)
		else $error("tdo not driven");
	a_jtag_sel_exact: assert property (port_sel_wr |=>
		jtag_selected == ($past(port_sel_wdata) == PORT_SEL_JTAG)) else $error("jtag select");
	a_trace_bit_wr: assert property (mon_ctrl_wr |=>
		trace_enable == $past(mon_ctrl_wdata[TRACE_BIT])) else $error("trace bit");
	a_trace_pin_out: assert property (debug_mode == DBRPC_SWD_TR |=>
		gpio_pin_16_oe && gpio_pin_16_o == $past(trace_data)) else $error("trace pin");
	a_boot_exclusive: assert property (boot_valid |-> flash_boot != serial_loader_mode)
		else $error("boot path not exclusive");
	a_boot_held: assert property (boot_valid |=> boot_valid && $stable(flash_boot))
		else $error("boot choice changed");
	a_loader_tx_pin: assert property (s_loader_on |-> gpio_pin_10_oe)
		else $error("uart tx pin not driven");
	a_dbnc_not_early: assert property ($rose(func_reset) |-> low_cnt_q >= lim)
		else $error("module reset too early");
	a_dbnc_not_late: assert property (low_cnt_q == lim + 32'h8 |-> func_reset)
		else $error("module reset too late");
	a_pwr_not_early: assert property ($rose(power_reset) |-> low_cnt_q >= PWR_HOLD)
		else $error("power reset too early");
	a_pwr_not_late: assert property (low_cnt_q == PWR_HOLD + 32'h8 |-> power_reset)
		else $error("power reset too late");
	a_high_clears: assert property (global_reset_pin [*5] |-> !func_reset && !power_reset)
		else $error("reset outputs not cleared");
endmodule

`default_nettype wire

// ---- bench/dbrpc_probe_model.sv ----
// behavioural debug probe: drives the clock pin, the data pin and the tdi pin
// assumes the bench frames each transfer; clock stands still between frames
`timescale 1ns/1ps
`default_nettype none

module dbrpc_probe_model (
	input  wire logic frame,
	input  wire logic data,
	input  wire logic dut_o17,
	input  wire logic dut_oe17,
	output var  logic clk_pin,
	output var  logic tdi_pin,
	output var  logic pin17
);
	logic drv;
	initial begin
		clk_pin = 1'b0;
		drv = 1'b0;
		#37;
	end
	// 160 ns probe clock, only while a frame is open
	always begin
		#80;
		clk_pin = frame ? ~clk_pin : 1'b0;
	end
	// data is set up as the frame opens, then moves on falling edges only,
	// so the first rising edge already sees the frame's level
	always @(negedge clk_pin or posedge frame) if (frame) drv <= data;
	// released line shows no stale value
	always @(negedge frame) drv <= ~drv;
	assign tdi_pin = drv;
	// two-way data pin: device drive wins while its enable is high
	assign pin17 = dut_oe17 ? dut_o17 : drv;
endmodule

`default_nettype wire

// ---- bench/tb_dbrpc_pin_ctrl.sv ----
// self-checking bench for the pin control block with a probe model
// assumes shortened debounce: step 20 cycles, power hold 200 cycles
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s expected %0h seen %0h", nm, e, g); end end

module tb_dbrpc_pin_ctrl;
	import dbrpc_pkg::*;
	logic core_clk, reset, probe_clk, debug_gate_pin, global_reset_pin, gpio_pin_5_i;
	logic gpio_pin_5_o, gpio_pin_5_oe, gpio_pin_5_pd, gpio_pin_10_i, gpio_pin_10_o;
	logic gpio_pin_10_oe, gpio_pin_11_i, gpio_pin_11_o, gpio_pin_11_oe, gpio_pin_15_i;
	logic gpio_pin_15_o, gpio_pin_15_oe, gpio_pin_16_i, gpio_pin_16_o, gpio_pin_16_oe;
	logic gpio_pin_17_i, gpio_pin_17_o, gpio_pin_17_oe, gpio_pin_18_o, gpio_pin_18_oe;
	logic [6:0] sw_pin_o, sw_pin_oe, sw_pin_i;
	logic mon_ctrl_wr, port_sel_wr, dbg_off_wr, dbg_off_wdata, trace_data, uart_txd;
	logic [31:0] mon_ctrl_wdata, port_sel_wdata;
	logic [2:0] dbnc_sel;
	logic uart_rxd, dbg_tdo, dbg_swdio_o, dbg_swdio_oe, dbg_tdi, dbg_tms_swdio, dbg_link_en;
	logic trace_enable, jtag_selected, boot_valid, flash_boot, serial_loader_mode;
	logic func_reset, power_reset, strap_en, strap_val, pframe, pdata;
	dbrpc_mode_t debug_mode;
	int mismatches, total_checks, n;

	dbrpc_probe_model dbrpc_probe_model_inst (.frame(pframe), .data(pdata),
		.dut_o17(gpio_pin_17_o), .dut_oe17(gpio_pin_17_oe), .clk_pin(probe_clk),
		.tdi_pin(gpio_pin_15_i), .pin17(gpio_pin_17_i));
	dbrpc_pin_ctrl #(.DBNC_STEP(32'h14), .PWR_HOLD(32'hC8)) dbrpc_pin_ctrl_inst (.core_clk,
		.reset, .probe_clk, .debug_gate_pin, .global_reset_pin, .gpio_pin_5_i, .gpio_pin_5_o,
		.gpio_pin_5_oe, .gpio_pin_5_pd, .gpio_pin_10_i, .gpio_pin_10_o, .gpio_pin_10_oe,
		.gpio_pin_11_i, .gpio_pin_11_o, .gpio_pin_11_oe, .gpio_pin_15_i, .gpio_pin_15_o,
		.gpio_pin_15_oe, .gpio_pin_16_i, .gpio_pin_16_o, .gpio_pin_16_oe, .gpio_pin_17_i,
		.gpio_pin_17_o, .gpio_pin_17_oe, .gpio_pin_18_i(probe_clk), .gpio_pin_18_o,
		.gpio_pin_18_oe, .sw_pin_o, .sw_pin_oe, .sw_pin_i, .mon_ctrl_wr, .mon_ctrl_wdata,
		.port_sel_wr, .port_sel_wdata, .dbg_off_wr, .dbg_off_wdata, .dbnc_sel, .trace_data,
		.uart_txd, .uart_rxd, .dbg_tdo, .dbg_swdio_o, .dbg_swdio_oe, .dbg_tdi, .dbg_tms_swdio,
		.dbg_link_en, .debug_mode, .trace_enable, .jtag_selected, .boot_valid, .flash_boot,
		.serial_loader_mode, .func_reset, .power_reset);

	// undriven strap pin falls to whatever the internal pull leaves
	assign gpio_pin_5_i = strap_en ? strap_val : !gpio_pin_5_pd;
	always #2.5 core_clk = ~core_clk;

	task tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task do_reset(input logic s);
		strap_en = s;
		strap_val = s;
		reset = 1'b1;
		tick(6);
		reset = 1'b0;
		tick(8);
	endtask
	// one-cycle settings write; k picks monitor, port select or off bit
	task wr(input int k, input logic [31:0] d);
		mon_ctrl_wr = (k == 0);
		port_sel_wr = (k == 1);
		dbg_off_wr = (k == 2);
		mon_ctrl_wdata = d;
		port_sel_wdata = d;
		dbg_off_wdata = d[0];
		tick(1);
		{mon_ctrl_wr, port_sel_wr, dbg_off_wr} = 3'h0;
		tick(3);
	endtask
	// four probe clocks of a constant level, then the clock stops
	task probe(input logic v);
		pdata = v;
		pframe = 1'b1;
		#640;
		pframe = 1'b0;
		tick(1);
	endtask

	task t_boot_flash;
		do_reset(1'b0);
		`CHK("flash_boot", 1'b1, flash_boot)
		`CHK("debug_mode", DBRPC_SWD_TR, debug_mode)
		trace_data = 1'b1;
		sw_pin_oe[0] = 1'b1;
		sw_pin_oe[1] = 1'b1;
		sw_pin_o[1] = 1'b1;
		tick(3);
		`CHK("pin16_o", 1'b1, gpio_pin_16_o)
		`CHK("pin10_oe", 1'b1, gpio_pin_10_oe)
		strap_en = 1'b1;
		strap_val = 1'b1;
		tick(6);
		`CHK("flash_hold", 1'b1, flash_boot)
		sw_pin_oe = 7'h00;
	endtask
	task t_trace_off;
		wr(0, 32'h0000_0000);
		`CHK("mode_swd", DBRPC_SWD, debug_mode)
		sw_pin_oe[4] = 1'b1;
		sw_pin_o[4] = 1'b1;
		trace_data = 1'b0;
		tick(2);
		`CHK("pin16_sw", 1'b1, gpio_pin_16_o)
		sw_pin_oe = 7'h00;
	endtask
	task t_jtag;
		wr(1, 32'h0000_0002);
		`CHK("jtag_sel", 1'b0, jtag_selected)
		wr(1, PORT_SEL_JTAG);
		`CHK("mode_jtag", DBRPC_JTAG, debug_mode)
		dbg_tdo = 1'b1;
		sw_pin_oe = 7'h7F;
		tick(4);
		`CHK("tdo_pin", 1'b1, gpio_pin_16_o)
		`CHK("jtag_in_oe", 3'h0, {gpio_pin_18_oe, gpio_pin_17_oe, gpio_pin_15_oe})
		sw_pin_oe = 7'h00;
		probe(1'b1);
		`CHK("tdi", 1'b1, dbg_tdi)
		`CHK("link_en", 1'b1, dbg_link_en)
		probe(1'b0);
		`CHK("tdi", 1'b0, dbg_tdi)
		`CHK("tms", 1'b0, dbg_tms_swdio)
	endtask
	task t_swd;
		wr(1, 32'h0000_0000);
		`CHK("mode_swd", DBRPC_SWD, debug_mode)
		probe(1'b1);
		`CHK("swdio_in", 1'b1, dbg_tms_swdio)
		`CHK("tdi_idle", 1'b0, dbg_tdi)
		dbg_swdio_oe = 1'b1;
		dbg_swdio_o = 1'b0;
		tick(5);
		`CHK("swdio_oe", 1'b1, gpio_pin_17_oe)
		`CHK("swdio_o", 1'b0, gpio_pin_17_o)
		dbg_swdio_oe = 1'b0;
	endtask
	task t_off_and_gate;
		wr(2, 32'h1);
		`CHK("mode_off", DBRPC_OFF, debug_mode)
		sw_pin_oe[5] = 1'b1;
		sw_pin_o[5] = 1'b1;
		tick(2);
		`CHK("pin17_sw", 1'b1, gpio_pin_17_o)
		wr(2, 32'h0);
		debug_gate_pin = 1'b0;
		gpio_pin_16_i = 1'b1;
		tick(5);
		`CHK("gate_off", DBRPC_OFF, debug_mode)
		`CHK("sw_in16", 1'b1, sw_pin_i[4])
		debug_gate_pin = 1'b1;
		tick(5);
		`CHK("gate_on", DBRPC_SWD, debug_mode)
		sw_pin_oe = 7'h00;
	endtask
	task t_loader;
		do_reset(1'b1);
		`CHK("loader", 1'b1, serial_loader_mode)
		uart_txd = 1'b0;
		gpio_pin_11_i = 1'b0;
		sw_pin_oe[2] = 1'b1;
		tick(4);
		`CHK("tx_pin", 1'b0, gpio_pin_10_o)
		`CHK("rx_pin_oe", 1'b0, gpio_pin_11_oe)
		`CHK("rx", 1'b0, uart_rxd)
		strap_en = 1'b0;
		tick(4);
		`CHK("loader_hold", 1'b1, serial_loader_mode)
		sw_pin_oe = 7'h00;
	endtask
	// debounce of 40 cycles with select 1; short pulse must be ignored
	task t_rst_pin;
		dbnc_sel = 3'h1;
		global_reset_pin = 1'b0;
		tick(30);
		global_reset_pin = 1'b1;
		tick(4);
		`CHK("short_pulse", 1'b0, func_reset)
		global_reset_pin = 1'b0;
		for (n = 0; n < 100 && func_reset !== 1'b1; n++) tick(1);
		`CHK("dbnc_time", 1'b1, n >= 40 && n <= 48)
		for (n = 0; n < 300 && power_reset !== 1'b1; n++) tick(1);
		`CHK("power_reset", 1'b1, power_reset)
		global_reset_pin = 1'b1;
		tick(5);
		`CHK("release", 2'h0, {func_reset, power_reset})
	endtask

	initial begin
		{core_clk, mismatches, total_checks, pframe, pdata, dbg_tdo} = '0;
		{dbg_swdio_o, dbg_swdio_oe, trace_data, sw_pin_o, sw_pin_oe} = '0;
		{mon_ctrl_wr, port_sel_wr, dbg_off_wr, dbg_off_wdata, dbnc_sel} = '0;
		{mon_ctrl_wdata, port_sel_wdata, gpio_pin_10_i, gpio_pin_16_i} = '0;
		{debug_gate_pin, global_reset_pin, gpio_pin_11_i, uart_txd} = 4'hF;
		t_boot_flash();
		t_trace_off();
		t_jtag();
		t_swd();
		t_off_and_gate();
		t_loader();
		t_rst_pin();
		tally_and_finish();
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge core_clk);
		mismatches++;
		tally_and_finish();
	end
endmodule

bind dbrpc_pin_ctrl dbrpc_pin_ctrl_chk #(.DBNC_STEP(DBNC_STEP), .PWR_HOLD(PWR_HOLD)) chk_inst (
	.core_clk(core_clk), .reset(reset), .debug_gate_pin(debug_gate_pin),
	.global_reset_pin(global_reset_pin), .gpio_pin_5_pd(gpio_pin_5_pd),
	.gpio_pin_10_oe(gpio_pin_10_oe), .gpio_pin_16_o(gpio_pin_16_o),
	.gpio_pin_16_oe(gpio_pin_16_oe), .gpio_pin_17_oe(gpio_pin_17_oe), .sw_pin_oe(sw_pin_oe),
	.mon_ctrl_wr(mon_ctrl_wr), .mon_ctrl_wdata(mon_ctrl_wdata), .port_sel_wr(port_sel_wr),
	.port_sel_wdata(port_sel_wdata), .dbnc_sel(dbnc_sel), .trace_data(trace_data),
	.debug_mode(debug_mode), .trace_enable(trace_enable), .jtag_selected(jtag_selected),
	.boot_valid(boot_valid), .flash_boot(flash_boot), .serial_loader_mode(serial_loader_mode),
	.func_reset(func_reset), .power_reset(power_reset));

`default_nettype wire

// ---- shared/dbrpc_pkg.sv ----
// constants and mode encoding for the debug, boot strap and reset pin control
// assumes a 200 MHz core clock and a probe clock that may stop between frames
package dbrpc_pkg;

	// debug port personality of the four shared pins
	typedef enum logic [1:0] {
		DBRPC_OFF    = 2'b00,
		DBRPC_SWD_TR = 2'b01,
		DBRPC_SWD    = 2'b10,
		DBRPC_JTAG   = 2'b11
	} dbrpc_mode_t;

	// position of each muxed pin in the internal pin vectors
	localparam int PIN_N  = 7;
	localparam int IX_P5  = 0;
	localparam int IX_P10 = 1;
	localparam int IX_P11 = 2;
	localparam int IX_P15 = 3;
	localparam int IX_P16 = 4;
	localparam int IX_P17 = 5;
	localparam int IX_P18 = 6;

	// register fields and values after reset
	localparam int          TRACE_BIT     = 24;
	localparam logic [31:0] MON_CTRL_RST  = 32'h0100_0000;
	localparam logic [31:0] PORT_SEL_JTAG = 32'h0000_0001;
	localparam logic        PORT_SEL_RST  = 1'b0;
	localparam logic        DBG_OFF_RST   = 1'b0;
	localparam logic        STRAP_PD_RST  = 1'b1;

	// timing
	localparam int CORE_MHZ      = 200;
	localparam int DBNC_STEP_US  = 500;
	localparam int PWR_HOLD_S    = 5;
	localparam int DBNC_STEP_CYC = DBNC_STEP_US * CORE_MHZ;
	localparam int PWR_HOLD_CYC  = PWR_HOLD_S * 1000000 * CORE_MHZ;
	localparam logic [1:0] STRAP_WAIT = 2'h3;

endpackage

// ---- src/dbrpc_pin_ctrl.sv ----
// pin control for the debug port, the start-up strap and the global reset pin
// assumes pin inputs are asynchronous to core_clk; debug core signals arrive
// on probe_clk, which the probe drives on the clock pin and may stop
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - one debug port, either four-pin JTAG or two-pin serial-wire debug.
// - software can switch the debug port off, freeing the shared pins.
// - debug gate pin high enables debug on pins 15 to 18.
// - debug gate pin low disables debug; pins 15 to 18 are plain I/O.
// - after power-up, pin 15 is I/O and pin 16 carries trace.
// - clearing monitor control bit 24 frees pins 15 and 16 as I/O.
// - writing 1 to port select gives JTAG: TDI, TDO, TMS, TCK on 15-18.
// - serial-wire mode uses pin 17 as data and pin 18 as clock.
// - strap low at power-on reset release starts from internal flash.
// - strap high enters serial loader; pin 10 UART transmit, pin 11 receive.
// - strap pin is pulled low internally, so undriven means flash start.
// - low on global reset pin beyond 500 us to 4 ms resets modules.
// - low beyond 5 s also resets the power domains.
module dbrpc_pin_ctrl #(
	parameter logic [31:0] DBNC_STEP = 32'(dbrpc_pkg::DBNC_STEP_CYC),
	parameter logic [31:0] PWR_HOLD  = 32'(dbrpc_pkg::PWR_HOLD_CYC)
) (
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	input  wire logic                  probe_clk,
	input  wire logic                  debug_gate_pin,
	input  wire logic                  global_reset_pin,
	input  wire logic                  gpio_pin_5_i,
	output var  logic                  gpio_pin_5_o,
	output var  logic                  gpio_pin_5_oe,
	output var  logic                  gpio_pin_5_pd,
	input  wire logic                  gpio_pin_10_i,
	output var  logic                  gpio_pin_10_o,
	output var  logic                  gpio_pin_10_oe,
	input  wire logic                  gpio_pin_11_i,
	output var  logic                  gpio_pin_11_o,
	output var  logic                  gpio_pin_11_oe,
	input  wire logic                  gpio_pin_15_i,
	output var  logic                  gpio_pin_15_o,
	output var  logic                  gpio_pin_15_oe,
	input  wire logic                  gpio_pin_16_i,
	output var  logic                  gpio_pin_16_o,
	output var  logic                  gpio_pin_16_oe,
	input  wire logic                  gpio_pin_17_i,
	output var  logic                  gpio_pin_17_o,
	output var  logic                  gpio_pin_17_oe,
	input  wire logic                  gpio_pin_18_i,
	output var  logic                  gpio_pin_18_o,
	output var  logic                  gpio_pin_18_oe,
	input  wire logic [6:0]            sw_pin_o,
	input  wire logic [6:0]            sw_pin_oe,
	output var  logic [6:0]            sw_pin_i,
	input  wire logic                  mon_ctrl_wr,
	input  wire logic [31:0]           mon_ctrl_wdata,
	input  wire logic                  port_sel_wr,
	input  wire logic [31:0]           port_sel_wdata,
	input  wire logic                  dbg_off_wr,
	input  wire logic                  dbg_off_wdata,
	input  wire logic [2:0]            dbnc_sel,
	input  wire logic                  trace_data,
	input  wire logic                  uart_txd,
	output var  logic                  uart_rxd,
	input  wire logic                  dbg_tdo,
	input  wire logic                  dbg_swdio_o,
	input  wire logic                  dbg_swdio_oe,
	output var  logic                  dbg_tdi,
	output var  logic                  dbg_tms_swdio,
	output var  logic                  dbg_link_en,
	output var  dbrpc_pkg::dbrpc_mode_t debug_mode,
	output var  logic                  trace_enable,
	output var  logic                  jtag_selected,
	output var  logic                  boot_valid,
	output var  logic                  flash_boot,
	output var  logic                  serial_loader_mode,
	output var  logic                  func_reset,
	output var  logic                  power_reset
);
	import dbrpc_pkg::*;

	// core domain state
	typedef struct packed {
		logic              gate_s1;
		logic              gate_s2;
		logic              grst_s1;
		logic              grst_s2;
		logic [6:0]        pin_s1;
		logic [6:0]        pin_s2;
		logic              tdo_s1;
		logic              tdo_s2;
		logic              sdo_s1;
		logic              sdo_s2;
		logic              soe_s1;
		logic              soe_s2;
		logic              trace_en;
		logic              jtag_sel;
		logic              dbg_off;
		dbrpc_mode_t       mode;
		logic              link_en;
		logic              link_jtag;
		logic [6:0]        pin_o;
		logic [6:0]        pin_oe;
		logic [6:0]        user_i;
		logic              pd;
		logic [1:0]        strap_cnt;
		logic              strap_done;
		logic              loader;
		logic              flash;
		logic              uart_rx;
		logic              func_rst;
		logic              pwr_rst;
	} dbrpc_core_t;

	// probe clock domain state
	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic en_s1;
		logic en_s2;
		logic jt_s1;
		logic jt_s2;
		logic tdi;
		logic tms;
		logic link_en;
	} dbrpc_link_t;

	dbrpc_core_t state_q;
	dbrpc_core_t state_d;
	dbrpc_link_t link_q;
	dbrpc_link_t link_d;
	logic [6:0]  pin_i;
	logic        flt_func;
	logic        flt_pwr;

	// true where a pin is taken from the user by debug or by the loader;
	// used for the drive path and for masking what the user reads back
	function automatic logic pin_owned(dbrpc_mode_t m, logic ldr, int ix);
		logic own;
		own = 1'b0;
		unique case (m)
			DBRPC_OFF:    own = 1'b0;
			DBRPC_SWD_TR: own = (ix == IX_P16) || (ix == IX_P17) || (ix == IX_P18);
			DBRPC_SWD:    own = (ix == IX_P17) || (ix == IX_P18);
			DBRPC_JTAG:   own = (ix >= IX_P15);
		endcase
		if (ldr && ((ix == IX_P10) || (ix == IX_P11))) begin
			own = 1'b1;
		end
		return own;
	endfunction

	// gather pin inputs in index order
	assign pin_i = {gpio_pin_18_i, gpio_pin_17_i, gpio_pin_16_i, gpio_pin_15_i,
	                gpio_pin_11_i, gpio_pin_10_i, gpio_pin_5_i};

	// reset pin filter runs on the synchronised, inverted pin level
	dbrpc_rst_filter #(
		.STEP_CYC (DBNC_STEP),
		.PWR_CYC  (PWR_HOLD)
	) u_filter (
		.core_clk (core_clk),
		.reset    (reset),
		.pin_low  (!state_q.grst_s2),
		.dbnc_sel (dbnc_sel),
		.func_rst (flt_func),
		.pwr_rst  (flt_pwr)
	);

	// core next state: synchronisers, settings, mode decode, pin routing
	always_comb begin
		state_d = state_q;

		// two-flop synchronisers for every asynchronous input
		state_d.gate_s1 = debug_gate_pin;
		state_d.gate_s2 = state_q.gate_s1;
		state_d.grst_s1 = global_reset_pin;
		state_d.grst_s2 = state_q.grst_s1;
		state_d.pin_s1  = pin_i;
		state_d.pin_s2  = state_q.pin_s1;
		state_d.tdo_s1  = dbg_tdo;
		state_d.tdo_s2  = state_q.tdo_s1;
		state_d.sdo_s1  = dbg_swdio_o;
		state_d.sdo_s2  = state_q.sdo_s1;
		state_d.soe_s1  = dbg_swdio_oe;
		state_d.soe_s2  = state_q.soe_s1;

		// software settings
		if (mon_ctrl_wr) begin
			state_d.trace_en = mon_ctrl_wdata[TRACE_BIT];
		end
		if (port_sel_wr) begin
			state_d.jtag_sel = (port_sel_wdata == PORT_SEL_JTAG);
		end
		if (dbg_off_wr) begin
			state_d.dbg_off = dbg_off_wdata;
		end

		// mode decode; the gate pin overrides every software setting
		if (!state_q.gate_s2) begin
			state_d.mode = DBRPC_OFF;
		end else if (state_q.dbg_off) begin
			state_d.mode = DBRPC_OFF;
		end else if (state_q.jtag_sel) begin
			state_d.mode = DBRPC_JTAG;
		end else if (state_q.trace_en) begin
			state_d.mode = DBRPC_SWD_TR;
		end else begin
			state_d.mode = DBRPC_SWD;
		end
		state_d.link_en   = (state_q.mode != DBRPC_OFF);
		state_d.link_jtag = (state_q.mode == DBRPC_JTAG);

		// default: every pin follows the user, reads are masked where owned
		for (int i = 0; i < PIN_N; i++) begin
			state_d.pin_o[i]  = sw_pin_o[i];
			state_d.pin_oe[i] = sw_pin_oe[i];
			state_d.user_i[i] = pin_owned(state_q.mode, state_q.loader, i)
			                    ? 1'b0 : state_q.pin_s2[i];
			if (pin_owned(state_q.mode, state_q.loader, i)) begin
				state_d.pin_o[i]  = 1'b0;
				state_d.pin_oe[i] = 1'b0;
			end
		end

		// debug personality of pins 15 to 18; unlisted owned pins are inputs
		unique case (state_q.mode)
			DBRPC_OFF: begin
			end
			DBRPC_SWD_TR: begin
				state_d.pin_o[IX_P16]  = trace_data;
				state_d.pin_oe[IX_P16] = 1'b1;
				state_d.pin_o[IX_P17]  = state_q.sdo_s2;
				state_d.pin_oe[IX_P17] = state_q.soe_s2;
			end
			DBRPC_SWD: begin
				state_d.pin_o[IX_P17]  = state_q.sdo_s2;
				state_d.pin_oe[IX_P17] = state_q.soe_s2;
			end
			DBRPC_JTAG: begin
				state_d.pin_o[IX_P16]  = state_q.tdo_s2;
				state_d.pin_oe[IX_P16] = 1'b1;
			end
		endcase

		// serial loader takes pins 10 and 11 for the UART
		if (state_q.loader) begin
			state_d.pin_o[IX_P10]  = uart_txd;
			state_d.pin_oe[IX_P10] = 1'b1;
			state_d.uart_rx        = state_q.pin_s2[IX_P11];
		end else begin
			state_d.uart_rx = 1'b1;
		end

		// strap: wait for the synchroniser to fill, then sample exactly once;
		// pin 5 is never driven before that so the strap is not self-made
		if (!state_q.strap_done) begin
			state_d.pin_oe[IX_P5] = 1'b0;
			if (state_q.strap_cnt == STRAP_WAIT) begin
				state_d.strap_done = 1'b1;
				state_d.loader     = state_q.pin_s2[IX_P5];
				state_d.flash      = !state_q.pin_s2[IX_P5];
			end else begin
				state_d.strap_cnt = state_q.strap_cnt + 2'h1;
			end
		end
		state_d.pd = STRAP_PD_RST;

		// reset requests re-registered for the top outputs
		state_d.func_rst = flt_func;
		state_d.pwr_rst  = flt_pwr;
	end

	// core registers; reset stands for power-on reset of this block
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q            <= '0;
			state_q.gate_s1    <= 1'b0;
			state_q.grst_s1    <= 1'b1;
			state_q.grst_s2    <= 1'b1;
			state_q.trace_en   <= MON_CTRL_RST[TRACE_BIT];
			state_q.jtag_sel   <= PORT_SEL_RST;
			state_q.dbg_off    <= DBG_OFF_RST;
			state_q.mode       <= DBRPC_OFF;
			state_q.pd         <= STRAP_PD_RST;
			state_q.uart_rx    <= 1'b1;
		end else begin
			state_q <= state_d;
		end
	end

	// probe side: samples TDI and TMS/SWDIO on the probe's own clock edge;
	// mode bits arrive as quasi-static levels through two flops each
	always_comb begin
		link_d        = link_q;
		link_d.rst_s1 = reset;
		link_d.rst_s2 = link_q.rst_s1;
		link_d.en_s1  = state_q.link_en;
		link_d.en_s2  = link_q.en_s1;
		link_d.jt_s1  = state_q.link_jtag;
		link_d.jt_s2  = link_q.jt_s1;
		link_d.link_en = link_q.en_s2;
		// idle values keep the debug core quiet while the port is off
		link_d.tdi = link_q.en_s2 && link_q.jt_s2 && gpio_pin_15_i;
		link_d.tms = link_q.en_s2 ? gpio_pin_17_i : 1'b1;
		if (link_q.rst_s2) begin
			link_d.link_en = 1'b0;
			link_d.tdi     = 1'b0;
			link_d.tms     = 1'b1;
		end
	end

	// probe clock registers; clock may stop, so no state waits on it
	always_ff @(posedge probe_clk) begin
		link_q <= link_d;
	end

	// outputs, all straight from registers
	assign gpio_pin_5_o       = state_q.pin_o[IX_P5];
	assign gpio_pin_5_oe      = state_q.pin_oe[IX_P5];
	assign gpio_pin_5_pd      = state_q.pd;
	assign gpio_pin_10_o      = state_q.pin_o[IX_P10];
	assign gpio_pin_10_oe     = state_q.pin_oe[IX_P10];
	assign gpio_pin_11_o      = state_q.pin_o[IX_P11];
	assign gpio_pin_11_oe     = state_q.pin_oe[IX_P11];
	assign gpio_pin_15_o      = state_q.pin_o[IX_P15];
	assign gpio_pin_15_oe     = state_q.pin_oe[IX_P15];
	assign gpio_pin_16_o      = state_q.pin_o[IX_P16];
	assign gpio_pin_16_oe     = state_q.pin_oe[IX_P16];
	assign gpio_pin_17_o      = state_q.pin_o[IX_P17];
	assign gpio_pin_17_oe     = state_q.pin_oe[IX_P17];
	assign gpio_pin_18_o      = state_q.pin_o[IX_P18];
	assign gpio_pin_18_oe     = state_q.pin_oe[IX_P18];
	assign sw_pin_i           = state_q.user_i;
	assign uart_rxd           = state_q.uart_rx;
	assign dbg_tdi            = link_q.tdi;
	assign dbg_tms_swdio      = link_q.tms;
	assign dbg_link_en        = link_q.link_en;
	assign debug_mode         = state_q.mode;
	assign trace_enable       = state_q.trace_en;
	assign jtag_selected      = state_q.jtag_sel;
	assign boot_valid         = state_q.strap_done;
	assign flash_boot         = state_q.flash;
	assign serial_loader_mode = state_q.loader;
	assign func_reset         = state_q.func_rst;
	assign power_reset        = state_q.pwr_rst;

endmodule

`default_nettype wire

// ---- src/dbrpc_rst_filter.sv ----
// low-level duration filter for the global reset pin
// assumes pin_low is already synchronised to core_clk
`timescale 1ns/1ps
`default_nettype none

module dbrpc_rst_filter #(
	parameter logic [31:0] STEP_CYC = 32'(dbrpc_pkg::DBNC_STEP_CYC),
	parameter logic [31:0] PWR_CYC  = 32'(dbrpc_pkg::PWR_HOLD_CYC)
) (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       pin_low,
	input  wire logic [2:0] dbnc_sel,
	output var  logic       func_rst,
	output var  logic       pwr_rst
);
	import dbrpc_pkg::*;

	typedef struct packed {
		logic [31:0] cnt;
		logic        func;
		logic        pwr;
	} dbrpc_flt_t;

	dbrpc_flt_t  state_q;
	dbrpc_flt_t  state_d;
	logic [31:0] limit;

	// debounce limit is 500 us times (sel + 1): 500 us up to 4 ms
	always_comb begin
		state_d = state_q;
		limit = STEP_CYC * (32'(dbnc_sel) + 32'h1);
		if (!pin_low) begin
			state_d.cnt = 32'h0;
		end else if (state_q.cnt != 32'hFFFF_FFFF) begin
			state_d.cnt = state_q.cnt + 32'h1;
		end
		// counter saturates so a pin held low for ages keeps both resets up
		state_d.func = pin_low && (state_q.cnt >= limit);
		state_d.pwr  = pin_low && (state_q.cnt >= PWR_CYC);
	end

	// one register stage for all filter state
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign func_rst = state_q.func;
	assign pwr_rst  = state_q.pwr;

endmodule

`default_nettype wire
